// ### design/lacr_pkg.sv
// Package: register offsets, field positions and reset values
package lacr_pkg;

	// Byte offsets; all printed offsets are indices, so byte address = 4*index
	localparam logic [7:0] IDX_AUDIO_GAIN = 8'h09;
	localparam logic [7:0] IDX_IMP_SYNTH  = 8'h0A;
	localparam logic [7:0] IDX_HYBRID     = 8'h0B;
	localparam logic [7:0] IDX_PWRDN1     = 8'h0E;
	localparam int         ADDR_W         = 12;
	localparam logic [ADDR_W-1:0] ADDR_AUDIO_GAIN = {2'h0, IDX_AUDIO_GAIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IMP_SYNTH  = {2'h0, IDX_IMP_SYNTH, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_HYBRID     = {2'h0, IDX_HYBRID, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PWRDN1     = {2'h0, IDX_PWRDN1, 2'h0};

	// Reset values
	localparam logic [7:0] RST_AUDIO_GAIN = 8'h00;
	localparam logic [7:0] RST_IMP_SYNTH  = 8'h08;
	localparam logic [7:0] RST_HYBRID     = 8'h00;
	localparam logic [7:0] RST_PWRDN1     = 8'h10;

	// Writable-bit masks; other bits are reserved and read zero
	localparam logic [7:0] MSK_AUDIO_GAIN = 8'hFF;
	localparam logic [7:0] MSK_IMP_SYNTH  = 8'h3F;
	localparam logic [7:0] MSK_HYBRID     = 8'h77;
	localparam logic [7:0] MSK_PWRDN1     = 8'h1B;

	// Field positions
	localparam int B_RX_HP   = 7;
	localparam int B_TX_HP   = 6;
	localparam int B_TX_MUTE = 5;
	localparam int B_RX_MUTE = 4;
	localparam int F_ATX_LO  = 2;
	localparam int F_ARX_LO  = 0;
	localparam int F_CLC_LO  = 4;
	localparam int B_ISE     = 3;
	localparam int F_ISS_LO  = 0;
	localparam int F_HYBP_LO = 4;
	localparam int F_HYBA_LO = 0;
	localparam int B_DC_OFF  = 4;
	localparam int B_PLL_FR  = 3;
	localparam int B_BIAS_OF = 1;
	localparam int B_LD_OFF  = 0;

	// Gain and hybrid codes
	localparam logic [1:0] GAIN_MUTE = 2'h3;
	localparam logic [2:0] HYB_OFF   = 3'h7;

	// Audio path controls to the analog/DSP blocks
	typedef struct packed {
		logic       rx_highpass_bypass;
		logic       tx_highpass_bypass;
		logic       tx_digital_mute;
		logic       rx_digital_mute;
		logic [1:0] analog_tx_gain_sel;
		logic [1:0] analog_rx_gain_sel;
		logic       analog_tx_mute;
		logic       analog_rx_mute;
	} lacr_audio_s;

	// Line and power controls
	typedef struct packed {
		logic [1:0] line_cap_comp_sel;
		logic       impedance_synth_enable;
		logic [2:0] impedance_synth_select;
		logic [2:0] metering_hybrid_adjust;
		logic       metering_hybrid_off;
		logic [2:0] audio_hybrid_adjust;
		logic       audio_hybrid_off;
		logic       converter_force_off;
		logic       pll_force_freerun;
		logic       bias_force_off;
		logic       line_driver_force_off;
	} lacr_line_s;

endpackage : lacr_pkg

// ### design/lacr_regs.sv
// Line audio configuration register bank with APB slave
//
// Overview of operation
// [RULE1] Audio gain bit 7: 0 enables receive high-pass, 1 bypasses it
// [RULE2] Audio gain bit 6: 0 enables transmit high-pass, 1 bypasses it
// [RULE3] Audio gain bit 5: 1 digitally mutes transmit path
// [RULE4] Audio gain bit 4: 1 digitally mutes receive path
// [RULE5] Bits 3:2 transmit gain 0, -3.5, +3.5 dB; 11 mutes at 0 dB
// [RULE6] Bits 1:0 receive gain 0, -3.5, +3.5 dB; 11 mutes receive
// [RULE7] Reserved bits always read back zero
// [RULE8] Bits 5:4 line capacitance compensation; code 11 reserved
// [RULE9] Impedance bit 3 enables two-wire impedance synthesis
// [RULE10] Bits 2:0 select one of eight synthesized impedances
// [RULE11] Hybrid bits 6:4 metering adjustment steps; 111 means off
// [RULE12] Hybrid bits 2:0 audio adjustment, same codes, 111 off
// [RULE13] Power-down bit 4 zero leaves converter automatic
// [RULE14] Power-down bit 3 one forces PLL free-run
// [RULE15] Power-down bit 1 one forces dc bias off
// [RULE16] Power-down bit 0 one forces line driver off
// [RULE17] Converter bit one forces converter off; reset value one
// [RULE18] Outputs follow stored values right after a write
`timescale 1ns/100ps
module lacr_regs
	import lacr_pkg::*;
(
	input  wire logic              CLK_I,
	input  wire logic              RST_N_I,
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]       PWDATA_I,
	input  wire logic [3:0]        PSTRB_I,
	output logic      [31:0]       PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O,
	output lacr_audio_s            AUDIO_CTRL_O,
	output lacr_line_s             LINE_CTRL_O
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	// Register select index: 0..3 mapped, 4 unmapped
	function automatic logic [2:0] dec(input logic [ADDR_W-1:0] a);
		if (a == ADDR_AUDIO_GAIN) begin
			dec = 3'h0;
		end else if (a == ADDR_IMP_SYNTH) begin
			dec = 3'h1;
		end else if (a == ADDR_HYBRID) begin
			dec = 3'h2;
		end else if (a == ADDR_PWRDN1) begin
			dec = 3'h3;
		end else begin
			dec = 3'h4;
		end
	endfunction : dec

	logic [2:0] sel;
	logic       acc;
	logic       wr_en;
	logic [7:0] audio_r;
	logic [7:0] imp_r;
	logic [7:0] hyb_r;
	logic [7:0] pwr_r;
	logic [7:0] rd_nxt;

	assign sel   = dec(PADDR_I);
	assign acc   = PSEL_I && PENABLE_I;
	// Only lane 0 carries register data; a write without it is ignored
	assign wr_en = acc && PWRITE_I && PSTRB_I[0] && (sel != 3'h4);

	// Zero wait states
	assign PREADY_O  = 1'b1;
	// Unmapped address answers with an error, reads give zero
	assign PSLVERR_O = acc && (sel == 3'h4);

	////////////////////////////////////////////////////////////////////////
	// Registers

	// [RULE7] reserved masked
	// Masking at write keeps reserved storage at zero, so read is plain
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			audio_r <= RST_AUDIO_GAIN;
			imp_r   <= RST_IMP_SYNTH;
			hyb_r   <= RST_HYBRID;
			pwr_r   <= RST_PWRDN1;
		end else if (wr_en) begin
			case (sel)
				3'h0: audio_r <= PWDATA_I[7:0] & MSK_AUDIO_GAIN;
				3'h1: imp_r   <= PWDATA_I[7:0] & MSK_IMP_SYNTH;
				3'h2: hyb_r   <= PWDATA_I[7:0] & MSK_HYBRID;
				3'h3: pwr_r   <= PWDATA_I[7:0] & MSK_PWRDN1;
				default: ;
			endcase
		end
	end

	// Read mux
	always_comb begin
		case (sel)
			3'h0:    rd_nxt = audio_r;
			3'h1:    rd_nxt = imp_r;
			3'h2:    rd_nxt = hyb_r;
			3'h3:    rd_nxt = pwr_r;
			default: rd_nxt = 8'h00;
		endcase
	end

	// Read data registered off the setup phase so it is valid in access
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			PRDATA_O <= {24'h00_0000, rd_nxt};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control outputs, straight from storage

	// [RULE18] direct drive
	always_comb begin
		// [RULE1] rx highpass
		AUDIO_CTRL_O.rx_highpass_bypass = audio_r[B_RX_HP];
		// [RULE2] tx highpass
		AUDIO_CTRL_O.tx_highpass_bypass = audio_r[B_TX_HP];
		// [RULE3] tx digital mute
		AUDIO_CTRL_O.tx_digital_mute    = audio_r[B_TX_MUTE];
		// [RULE4] rx digital mute
		AUDIO_CTRL_O.rx_digital_mute    = audio_r[B_RX_MUTE];
		// [RULE5] tx gain select
		AUDIO_CTRL_O.analog_tx_gain_sel = audio_r[F_ATX_LO +: 2];
		AUDIO_CTRL_O.analog_tx_mute     =
			(audio_r[F_ATX_LO +: 2] == GAIN_MUTE);
		// [RULE6] rx gain select
		AUDIO_CTRL_O.analog_rx_gain_sel = audio_r[F_ARX_LO +: 2];
		AUDIO_CTRL_O.analog_rx_mute     =
			(audio_r[F_ARX_LO +: 2] == GAIN_MUTE);
		// [RULE8] cap compensation
		LINE_CTRL_O.line_cap_comp_sel      = imp_r[F_CLC_LO +: 2];
		// [RULE9] synth enable
		LINE_CTRL_O.impedance_synth_enable = imp_r[B_ISE];
		// [RULE10] impedance select
		LINE_CTRL_O.impedance_synth_select = imp_r[F_ISS_LO +: 3];
		// [RULE11] metering hybrid
		LINE_CTRL_O.metering_hybrid_adjust = hyb_r[F_HYBP_LO +: 3];
		LINE_CTRL_O.metering_hybrid_off    =
			(hyb_r[F_HYBP_LO +: 3] == HYB_OFF);
		// [RULE12] audio hybrid
		LINE_CTRL_O.audio_hybrid_adjust    = hyb_r[F_HYBA_LO +: 3];
		LINE_CTRL_O.audio_hybrid_off       =
			(hyb_r[F_HYBA_LO +: 3] == HYB_OFF);
		// [RULE13] [RULE17] converter override
		LINE_CTRL_O.converter_force_off    = pwr_r[B_DC_OFF];
		// [RULE14] pll freerun
		LINE_CTRL_O.pll_force_freerun      = pwr_r[B_PLL_FR];
		// [RULE15] bias off
		LINE_CTRL_O.bias_force_off         = pwr_r[B_BIAS_OF];
		// [RULE16] line driver off
		LINE_CTRL_O.line_driver_force_off  = pwr_r[B_LD_OFF];
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	logic wr_q;
	logic [2:0] sel_q;
	logic [7:0] wd_q;
	always_ff @(posedge CLK_I) begin
		wr_q  <= RST_N_I && wr_en;
		sel_q <= sel;
		wd_q  <= PWDATA_I[7:0];
	end

	property p_rx_highpass_bypass;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h0 |->
			AUDIO_CTRL_O.rx_highpass_bypass == wd_q[7];
	endproperty
	a_rx_highpass_bypass: assert property (p_rx_highpass_bypass) else $error("rx hp bypass wrong"); // [RULE1]

	property p_tx_highpass_bypass;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h0 |->
			AUDIO_CTRL_O.tx_highpass_bypass == wd_q[6];
	endproperty
	a_tx_highpass_bypass: assert property (p_tx_highpass_bypass) else $error("tx hp bypass wrong"); // [RULE2]

	property p_txm;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h0 |-> AUDIO_CTRL_O.tx_digital_mute == wd_q[5];
	endproperty
	a_txm: assert property (p_txm) else $error("tx mute wrong"); // [RULE3]

	property p_rxm;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h0 |-> AUDIO_CTRL_O.rx_digital_mute == wd_q[4];
	endproperty
	a_rxm: assert property (p_rxm) else $error("rx mute wrong"); // [RULE4]

	property p_atx;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h0 |->
			AUDIO_CTRL_O.analog_tx_mute == (wd_q[3:2] == 2'h3);
	endproperty
	a_atx: assert property (p_atx) else $error("tx analog mute wrong"); // [RULE5]

	property p_arx;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h0 |->
			AUDIO_CTRL_O.analog_rx_mute == (wd_q[1:0] == 2'h3);
	endproperty
	a_arx: assert property (p_arx) else $error("rx analog mute wrong"); // [RULE6]

	property p_resv;
		@(posedge CLK_I) disable iff (!RST_N_I)
		PSEL_I && PENABLE_I && !PWRITE_I && sel == 3'h2 |->
			PRDATA_O[7] == 1'b0 && PRDATA_O[3] == 1'b0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bit nonzero"); // [RULE7]

	property p_clc;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h1 |-> LINE_CTRL_O.line_cap_comp_sel == wd_q[5:4]
			&& LINE_CTRL_O.impedance_synth_enable == wd_q[3]
			&& LINE_CTRL_O.impedance_synth_select == wd_q[2:0];
	endproperty
	a_clc: assert property (p_clc) else $error("impedance ctrl wrong"); // [RULE8]

	property p_hyb;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h2 |->
			LINE_CTRL_O.metering_hybrid_off == (wd_q[6:4] == 3'h7)
			&& LINE_CTRL_O.audio_hybrid_off == (wd_q[2:0] == 3'h7);
	endproperty
	a_hyb: assert property (p_hyb) else $error("hybrid off wrong"); // [RULE11]

	property p_pwr;
		@(posedge CLK_I)
		$rose(RST_N_I) |-> LINE_CTRL_O.converter_force_off
			&& !LINE_CTRL_O.pll_force_freerun;
	endproperty
	a_pwr: assert property (p_pwr) else $error("powerdown reset wrong"); // [RULE17]

	// Field checks compare against the captured write, one cycle later
	// Write data is checked raw, so a broken mask or slice shows up here
	property p_ise;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h1 |->
			LINE_CTRL_O.impedance_synth_enable == wd_q[3];
	endproperty
	a_ise: assert property (p_ise) // [RULE9]
		else $error("synth enable wrong");

	property p_iss;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h1 |->
			LINE_CTRL_O.impedance_synth_select == wd_q[2:0];
	endproperty
	a_iss: assert property (p_iss) // [RULE10]
		else $error("synth select wrong");

	property p_hybp;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h2 |->
			LINE_CTRL_O.metering_hybrid_adjust == wd_q[6:4];
	endproperty
	a_hybp: assert property (p_hybp) // [RULE11]
		else $error("metering hybrid wrong");

	property p_hyba;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h2 |->
			LINE_CTRL_O.audio_hybrid_adjust == wd_q[2:0]
			&& LINE_CTRL_O.audio_hybrid_off == (wd_q[2:0] == 3'h7);
	endproperty
	a_hyba: assert property (p_hyba) // [RULE12]
		else $error("audio hybrid wrong");

	property p_converter_force_off;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h3 |->
			LINE_CTRL_O.converter_force_off == wd_q[4];
	endproperty
	a_converter_force_off: assert property (p_converter_force_off) // [RULE13]
		else $error("converter control wrong");

	property p_pfr;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h3 |->
			LINE_CTRL_O.pll_force_freerun == wd_q[3];
	endproperty
	a_pfr: assert property (p_pfr) // [RULE14]
		else $error("pll freerun wrong");

	property p_bias;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h3 |->
			LINE_CTRL_O.bias_force_off == wd_q[1];
	endproperty
	a_bias: assert property (p_bias) // [RULE15]
		else $error("bias control wrong");

	property p_ldoff;
		@(posedge CLK_I) disable iff (!RST_N_I)
		wr_q && sel_q == 3'h3 |->
			LINE_CTRL_O.line_driver_force_off == wd_q[0];
	endproperty
	a_ldoff: assert property (p_ldoff) // [RULE16]
		else $error("line driver control wrong");

	// Outputs only move on the cycle after a write lands
	property p_hold;
		@(posedge CLK_I) disable iff (!RST_N_I)
		!wr_q |->
			$stable(AUDIO_CTRL_O) && $stable(LINE_CTRL_O);
	endproperty
	a_hold: assert property (p_hold) // [RULE18]
		else $error("control moved without write");

	// A write without lane 0 must leave every control alone
	property p_strb;
		@(posedge CLK_I) disable iff (!RST_N_I)
		PSEL_I && PENABLE_I && PWRITE_I && !PSTRB_I[0] |=>
			$stable(AUDIO_CTRL_O) && $stable(LINE_CTRL_O);
	endproperty
	a_strb: assert property (p_strb) // [RULE18]
		else $error("strobe-less write acted");

	property p_rdhi;
		@(posedge CLK_I) disable iff (!RST_N_I)
		PSEL_I && PENABLE_I && !PWRITE_I |->
			PRDATA_O[31:8] == 24'h00_0000;
	endproperty
	a_rdhi: assert property (p_rdhi) // [RULE7]
		else $error("upper read bits set");

	property p_rsvimp;
		@(posedge CLK_I) disable iff (!RST_N_I)
		PSEL_I && PENABLE_I && !PWRITE_I && sel == 3'h1 |->
			PRDATA_O[7:6] == 2'h0;
	endproperty
	a_rsvimp: assert property (p_rsvimp) // [RULE7]
		else $error("impedance reserved set");

	property p_rsvpwr;
		@(posedge CLK_I) disable iff (!RST_N_I)
		PSEL_I && PENABLE_I && !PWRITE_I && sel == 3'h3 |->
			PRDATA_O[7:5] == 3'h0 && PRDATA_O[2] == 1'b0;
	endproperty
	a_rsvpwr: assert property (p_rsvpwr) // [RULE7]
		else $error("powerdown reserved set");

endmodule : lacr_regs

// ### verif/test_lacr_regs.sv
// Self-checking bench for the line audio configuration register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_lacr_regs
	import lacr_pkg::*;
;
	logic              clk_i, rst_n_i, psel, penable, pwrite;
	logic              pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic [3:0]        pstrb;
	lacr_audio_s       audio;
	lacr_line_s        line;
	int                err_count, cmp_count, cyc;
	logic [7:0]        model [4];
	logic [ADDR_W-1:0] amap [4] = '{ADDR_AUDIO_GAIN, ADDR_IMP_SYNTH,
		ADDR_HYBRID, ADDR_PWRDN1};
	// Writable bits and reset values, as the register table gives them
	logic [7:0]        mmask [4] = '{8'hFF, 8'h3F, 8'h77, 8'h1B};
	logic [7:0]        mrst [4]  = '{8'h00, 8'h08, 8'h00, 8'h10};

	lacr_regs i_dut (
		.CLK_I(clk_i), .RST_N_I(rst_n_i), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr),
		.AUDIO_CTRL_O(audio), .LINE_CTRL_O(line)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; ceiling well above the ~9.4k cycles used
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// One APB transfer; waits on pready, samples at that edge only
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic er);
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Expected decoded outputs from the model bytes
	task automatic chk_all();
		lacr_audio_s ea;
		lacr_line_s  el;
		ea = '{model[0][7], model[0][6], model[0][5], model[0][4],
			model[0][3:2], model[0][1:0], model[0][3:2] == 2'h3,
			model[0][1:0] == 2'h3};
		el = '{model[1][5:4], model[1][3], model[1][2:0], model[2][6:4],
			model[2][6:4] == 3'h7, model[2][2:0], model[2][2:0] == 3'h7,
			model[3][4], model[3][3], model[3][1], model[3][0]};
		`CHK("audio", ea, audio)
		`CHK("line", el, line)
	endtask : chk_all

	// Transfer plus model update and comparison of every result
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int          k;
		logic        hit;
		logic [31:0] rd;
		logic        er;
		hit = 1'b0;
		k = 0;
		for (int i = 0; i < 4; i++) if (a == amap[i]) begin
			hit = 1'b1;
			k = i;
		end
		apb(wr, a, d, s, rd, er);
		`CHK("pslverr", !hit, er)
		if (!wr) `CHK("prdata", hit ? {24'h0, model[k]} : 32'h0, rd)
		else if (hit && s[0]) model[k] = d[7:0] & mmask[k];
		@(posedge clk_i);
		#1;
		chk_all();
	endtask : access

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int k;
		rst_n_i = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		{err_count, cmp_count, cyc} = 0;
		void'($urandom(32'hffc9dda8));
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		model = mrst;
		// Reset values
		for (int i = 0; i < 4; i++) access(1'b0, amap[i], 32'h0, 4'h0);
		// Every byte value into every register covers all field codes
		for (int v = 0; v < 256; v++) for (int i = 0; i < 4; i++) begin
			access(1'b1, amap[i], ($urandom & 32'hFFFFFF00) | v, 4'h1);
			access(1'b0, amap[i], 32'h0, 4'h0);
		end
		// Lane 0 strobe low must leave the register alone
		access(1'b1, ADDR_HYBRID, 32'h0000_0055, 4'hE);
		access(1'b0, ADDR_HYBRID, 32'h0, 4'h0);
		// Unmapped words refuse writes and read zero
		access(1'b1, 12'h030, 32'hFFFF_FFFF, 4'hF);
		access(1'b0, 12'h030, 32'h0, 4'h0);
		access(1'b0, 12'h000, 32'h0, 4'h0);
		// Random mixed traffic, some of it off the map
		repeat (300) begin
			k = $urandom_range(0, 4);
			access(1'($urandom_range(0, 1)),
				(k < 4) ? amap[k] : ADDR_W'($urandom << 2),
				$urandom, 4'($urandom));
		end
		// Second reset in mid-run restores reset values
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		model = mrst;
		for (int i = 0; i < 4; i++) access(1'b0, amap[i], 32'h0, 4'h0);
		results();
	end
endmodule : test_lacr_regs
